// ---- inc/rbs_params.svh ----
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define RBS_CLK_MHZ 25
`define RBS_HYST_NS 2000
`define RBS_OSC_STABLE_NS 100000
`define RBS_STRETCH_CYCLES 1024
`define RBS_CNT_W 16

// ----------------------------------------
// supply thresholds, millivolts
// ----------------------------------------
`define RBS_WARN_MV 2950
`define RBS_DROOP_MV 2650
`define RBS_POR_MV 1000

// ----------------------------------------
// reset values and vector
// ----------------------------------------
`define RBS_RESET_VECTOR 32'h0000_0000
`define RBS_SYNC_RESET 3'h7

// ----------------------------------------
// field positions in the comparator group
// ----------------------------------------
`define RBS_LVL_WARN 0
`define RBS_LVL_DROOP 1

`endif

// ---- inc/rbs_pkg.sv ----
`include "rbs_params.svh"

package rbs_pkg;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_OSC = 3'b001,
    ST_COUNT = 3'b010,
    ST_FLASH = 3'b011,
    ST_RUN = 3'b100
  } rbs_state_t;

  // pin and analogue comparator levels, all raw from the pads
  typedef struct packed {
    logic pin_n;
    logic warn_below;
    logic droop_below;
  } rbs_cmp_t;

  // least time in ns to whole cycles, never under one
  function automatic logic [`RBS_CNT_W-1:0] rbs_min_cycles(input int ns);
    int c;
    c = (ns * `RBS_CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[`RBS_CNT_W-1:0];
  endfunction : rbs_min_cycles

endpackage : rbs_pkg

// ---- core/rbs_sync.sv ----
module rbs_sync #(
  parameter int W = 3
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : rbs_sync

// ---- core/rbs_supervisor.sv ----
// What this block does
// - chip reset is asserted while pin, watchdog, power-on or droop asks.
// - any reset restarts the wake timer; release waits for pin, osc, count, flash.
// - on release the core starts fetching at address zero.
// - peripheral reset ends a cycle before core reset so all registers are set.
// - supply under the warning threshold raises a warning interrupt request.
// - the warning goes to the interrupt controller and to a pollable status bit.
// - supply under the droop threshold asserts chip reset, blocking flash writes.
// - droop reset holds as supply falls; power-on detect then keeps it.
// - both threshold indications have hysteresis so they do not chatter.
// - execution waits until the oscillator has been stable for a set time.
`include "rbs_params.svh"

module rbs_supervisor #(
  parameter logic [`RBS_CNT_W-1:0] STRETCH_CYCLES =
    `RBS_CNT_W'(`RBS_STRETCH_CYCLES)
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire rbs_pkg::rbs_cmp_t cmp_raw,
  input wire logic wdt_req,
  input wire logic por_det,
  input wire logic osc_ready,
  input wire logic flash_init_done,
  output logic core_rst_reg,
  output logic periph_rst_reg,
  output logic fetch_go_reg,
  output logic [31:0] fetch_addr_reg,
  output logic flash_init_req_reg,
  output logic warn_irq_reg,
  output logic warn_status_reg,
  output logic droop_rst_reg
);
  import rbs_pkg::*;

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic [`RBS_CNT_W-1:0] HYST_CYCLES =
    rbs_min_cycles(`RBS_HYST_NS);
  localparam logic [`RBS_CNT_W-1:0] OSC_CYCLES =
    rbs_min_cycles(`RBS_OSC_STABLE_NS);
  localparam int ONE = 1;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  rbs_cmp_t cmp_sync;

  rbs_sync #(
    .W(3)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .d(cmp_raw),
    .q(cmp_sync)
  );

  // ----------------------------------------
  // threshold hysteresis
  // ----------------------------------------
  logic [1:0] lvl_reg;
  logic [`RBS_CNT_W-1:0] hcnt_reg [2];
  wire [1:0] cmp_lvl = {cmp_sync.droop_below, cmp_sync.warn_below};

  // change after steady run
  // a level flips only after the comparator has disagreed for a whole
  // filter window; noise near a threshold just restarts the count
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (reset) begin
        lvl_reg[i] <= 1'b0;
        hcnt_reg[i] <= '0;
      end else if (cmp_lvl[i] == lvl_reg[i]) begin
        hcnt_reg[i] <= '0;
      end else if (hcnt_reg[i] == HYST_CYCLES - 1'b1) begin
        lvl_reg[i] <= cmp_lvl[i];
        hcnt_reg[i] <= '0;
      end else begin
        hcnt_reg[i] <= hcnt_reg[i] + 1'b1;
      end
    end
  end

  wire warn_lvl = lvl_reg[`RBS_LVL_WARN];
  wire droop_lvl = lvl_reg[`RBS_LVL_DROOP];

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  // asynchronous assertion
  // only pad-level sources may set reset without the clock
  wire raw_assert = por_det | ~cmp_raw.pin_n;
  // por keeps reset below droop range
  wire any_src = ~cmp_sync.pin_n | wdt_req | por_det | droop_lvl | reset;

  // ----------------------------------------
  // wake-up sequencer
  // ----------------------------------------
  rbs_state_t state_reg;
  rbs_state_t state_next;
  logic [`RBS_CNT_W-1:0] cnt_reg;
  logic [`RBS_CNT_W-1:0] cnt_next;

  wire osc_done = osc_ready && (cnt_reg == OSC_CYCLES - 1'b1);
  wire stretch_done = (cnt_reg == STRETCH_CYCLES - 1'b1);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    unique case (state_reg)
      ST_HOLD: begin
        cnt_next = '0;
        state_next = ST_OSC;
      end
      ST_OSC: begin
        if (!osc_ready) begin
          cnt_next = '0;
        end else if (osc_done) begin
          cnt_next = '0;
          state_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (stretch_done) begin
          cnt_next = '0;
          state_next = ST_FLASH;
        end
      end
      ST_FLASH: begin
        cnt_next = '0;
        if (flash_init_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_next = '0;
      end
      default: begin
        cnt_next = '0;
        state_next = ST_HOLD;
      end
    endcase
    if (any_src) begin
      cnt_next = '0;
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge core_clk or posedge raw_assert) begin
    if (raw_assert) begin
      state_reg <= ST_HOLD;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // reset outputs
  // ----------------------------------------
  wire periph_rst_next = (state_next != ST_RUN);
  wire core_rst_next = periph_rst_reg | periph_rst_next;

  always_ff @(posedge core_clk or posedge raw_assert) begin
    if (raw_assert) begin
      periph_rst_reg <= 1'b1;
      core_rst_reg <= 1'b1;
      fetch_go_reg <= 1'b0;
    end else begin
      periph_rst_reg <= periph_rst_next;
      core_rst_reg <= core_rst_next;
      fetch_go_reg <= core_rst_reg & ~core_rst_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || core_rst_reg) begin
      fetch_addr_reg <= `RBS_RESET_VECTOR;
    end else begin
      fetch_addr_reg <= fetch_addr_reg;
    end
  end

  // ----------------------------------------
  // droop monitor outputs
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      warn_irq_reg <= 1'b0;
      warn_status_reg <= 1'b0;
      droop_rst_reg <= 1'b0;
      flash_init_req_reg <= 1'b0;
    end else begin
      warn_irq_reg <= warn_lvl;
      warn_status_reg <= warn_lvl;
      droop_rst_reg <= droop_lvl;
      flash_init_req_reg <= (state_next == ST_FLASH);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_src_reset;
    @(posedge core_clk) disable iff (reset)
      wdt_req |-> ##[1:2] (core_rst_reg && periph_rst_reg);
  endproperty
  a_src_reset: assert property (p_src_reset)
    else $error("watchdog did not assert chip reset");

  property p_stretch;
    @(posedge core_clk) disable iff (reset)
      (state_reg == ST_FLASH && $past(state_reg) == ST_COUNT)
        |-> $past(cnt_reg) == STRETCH_CYCLES - 1'b1;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretch count cut short");

  property p_flash_wait;
    @(posedge core_clk) disable iff (reset)
      (state_reg == ST_RUN && $past(state_reg) == ST_FLASH)
        |-> $past(flash_init_done);
  endproperty
  a_flash_wait: assert property (p_flash_wait)
    else $error("left flash wait without done");

  property p_fetch;
    @(posedge core_clk) disable iff (reset)
      $fell(core_rst_reg) |->
        fetch_go_reg && fetch_addr_reg == `RBS_RESET_VECTOR;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch not started at vector");

  property p_order;
    @(posedge core_clk) disable iff (reset)
      $fell(core_rst_reg) |-> $past(!periph_rst_reg, ONE);
  endproperty
  a_order: assert property (p_order)
    else $error("core released before peripherals");

  property p_warn;
    @(posedge core_clk) disable iff (reset)
      warn_lvl |=> warn_irq_reg && warn_status_reg;
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning not raised");

  property p_droop;
    @(posedge core_clk) disable iff (reset)
      droop_lvl |=> droop_rst_reg ##[0:1] core_rst_reg;
  endproperty
  a_droop: assert property (p_droop)
    else $error("droop did not reset chip");

  property p_hyst;
    @(posedge core_clk) disable iff (reset)
      $changed(droop_lvl) |-> $past(hcnt_reg[1]) == HYST_CYCLES - 1'b1;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("droop level changed without filter");

  property p_osc;
    @(posedge core_clk) disable iff (reset)
      (state_reg == ST_COUNT && $past(state_reg) == ST_OSC)
        |-> $past(osc_ready) && $past(cnt_reg) == OSC_CYCLES - 1'b1;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator window too short");

endmodule : rbs_supervisor

// ---- sim/rbs_far_side.sv ----
module rbs_far_side #(
  parameter int FLASH_DLY = 6
) (
  input wire logic core_clk,
  input wire logic osc_on,
  input wire logic irq_en,
  input wire logic warn_irq_reg,
  input wire logic flash_init_req_reg,
  output logic osc_ready,
  output logic flash_init_done,
  output logic cpu_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0;
  assign cpu_irq = warn_irq_reg & irq_en;
  always @(posedge core_clk) begin
    osc_ready <= osc_on;
  end
  always @(posedge core_clk) begin
    if (flash_init_req_reg !== 1'b1) begin
      wait_cnt <= 0;
      flash_init_done <= 1'b0;
    end else if (wait_cnt < FLASH_DLY) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      flash_init_done <= 1'b1;
    end
  end
endmodule : rbs_far_side

// ---- sim/test_reset_and_brownout_supervisor.sv ----
module test_reset_and_brownout_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import rbs_pkg::*;
  logic core_clk, reset, wdt_req, por_det, osc_on, irq_en;
  rbs_cmp_t cmp_raw;
  logic osc_ready, flash_init_done, core_rst_reg, periph_rst_reg, cpu_irq;
  logic fetch_go_reg, flash_init_req_reg, warn_irq_reg, warn_status_reg;
  logic droop_rst_reg;
  logic [31:0] fetch_addr_reg;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;

  rbs_supervisor #(.STRETCH_CYCLES(16'h0004)) i_dut (
    .core_clk(core_clk), .reset(reset), .cmp_raw(cmp_raw),
    .wdt_req(wdt_req), .por_det(por_det), .osc_ready(osc_ready),
    .flash_init_done(flash_init_done), .core_rst_reg(core_rst_reg),
    .periph_rst_reg(periph_rst_reg), .fetch_go_reg(fetch_go_reg),
    .fetch_addr_reg(fetch_addr_reg),
    .flash_init_req_reg(flash_init_req_reg),
    .warn_irq_reg(warn_irq_reg), .warn_status_reg(warn_status_reg),
    .droop_rst_reg(droop_rst_reg));

  rbs_far_side i_far (
    .core_clk(core_clk), .osc_on(osc_on), .irq_en(irq_en),
    .warn_irq_reg(warn_irq_reg), .flash_init_req_reg(flash_init_req_reg),
    .osc_ready(osc_ready), .flash_init_done(flash_init_done),
    .cpu_irq(cpu_irq));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk_bit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [31:0] e,
                          input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word

  task automatic run(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : run

  // bounded wait for the start pulse, cycles counted into n
  task automatic wait_go();
    n = 0;
    while (fetch_go_reg !== 1'b1 && n < 4000) begin
      run(1);
      n++;
    end
    chk_bit("fetch_go", 1'b1, fetch_go_reg);
    chk_word("fetch_addr", 32'h0000_0000, fetch_addr_reg);
    chk_bit("core_rst", 1'b0, core_rst_reg);
    chk_bit("periph_rst", 1'b0, periph_rst_reg);
    chk_bit("flash_req", 1'b0, flash_init_req_reg);
  endtask : wait_go

  task automatic t_boot();
    wait_go();
    chk_bit("osc window", 1'b1, n >= 2504);
    run(1);
    chk_bit("go pulse end", 1'b0, fetch_go_reg);
  endtask : t_boot

  task automatic t_wdt();
    wdt_req <= 1'b1;
    run(1);
    wdt_req <= 1'b0;
    run(1);
    chk_bit("wdt core_rst", 1'b1, core_rst_reg);
    run(1000);
    osc_on <= 1'b0;
    run(5);
    osc_on <= 1'b1;
    wait_go();
    chk_bit("osc restart", 1'b1, n >= 2500);
  endtask : t_wdt

  task automatic t_pin();
    @(posedge core_clk);
    cmp_raw.pin_n <= 1'b0;
    #5;
    chk_bit("pin async", 1'b1, core_rst_reg);
    run(2700);
    chk_bit("pin held", 1'b1, core_rst_reg);
    cmp_raw.pin_n <= 1'b1;
    wait_go();
  endtask : t_pin

  task automatic t_warn();
    cmp_raw.warn_below <= 1'b1;
    run(30);
    cmp_raw.warn_below <= 1'b0;
    run(60);
    chk_bit("warn glitch", 1'b0, warn_irq_reg);
    cmp_raw.warn_below <= 1'b1;
    run(60);
    chk_bit("warn irq", 1'b1, warn_irq_reg);
    chk_bit("warn status", 1'b1, warn_status_reg);
    chk_bit("masked", 1'b0, cpu_irq);
    irq_en <= 1'b1;
    run(1);
    chk_bit("unmasked", 1'b1, cpu_irq);
    chk_bit("no reset", 1'b0, core_rst_reg);
    cmp_raw.warn_below <= 1'b0;
    run(60);
    chk_bit("warn clear", 1'b0, warn_status_reg);
  endtask : t_warn

  task automatic t_droop();
    cmp_raw.warn_below <= 1'b1;
    cmp_raw.droop_below <= 1'b1;
    run(58);
    chk_bit("droop rst", 1'b1, droop_rst_reg);
    chk_bit("droop core", 1'b1, core_rst_reg);
    por_det <= 1'b1;
    cmp_raw.droop_below <= 1'b0;
    run(60);
    chk_bit("por held", 1'b1, core_rst_reg);
    por_det <= 1'b0;
    cmp_raw.warn_below <= 1'b0;
    wait_go();
  endtask : t_droop

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // watchdog: four wake sequences take well under 30000 cycles
  initial begin
    #1200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    wdt_req = 1'b0;
    por_det = 1'b0;
    osc_on = 1'b1;
    irq_en = 1'b0;
    cmp_raw = '{pin_n: 1'b1, warn_below: 1'b0, droop_below: 1'b0};
    run(12);
    reset <= 1'b0;
    t_boot();
    t_wdt();
    t_pin();
    t_warn();
    t_droop();
    report_and_stop();
  end
endmodule : test_reset_and_brownout_supervisor
